// file: design/psa_pkg.sv
/*
  Constants and types for the program space access unit.
  Assumes a 16-bit core data side and a 24-bit word program flash, one clock.
*/
// Functional notes
// - Window address is visibility page over data address 14:0; bit 15 unused.
// - Low table ops reach program bits 15:0, high ops bits 23:16.
// - Byte-mode low read returns selected byte of low word in low data byte.
// - Word-mode high read returns bits 23:16 low, data bits 15:8 zero.
// - Byte-mode high read returns zero when the phantom byte is selected.
// - Table page bit 7 chooses configuration space, else user space.
// - Table target address is table page over effective address.
// - Program addresses advance by two per program word.
// - Window access only when data bit 15 set and core control bit 2 set.
// - Visibility page picks one of 256 pages of 16K words.
// - Data addresses 8000h upward map onto the selected page.
// - Window reads return only the low 16 bits of the program word.
// - Outside repeat, moves cost one extra cycle, others two.
// - In repeat, first, last and interrupt edges cost two, others none.
// - Window mapping is suspended during table operations.
// - Rows of 64 words, pages of eight rows, aligned from zero.
// - Erase a 512-word page, program one row or one word; the code also sends word programs to the row base address.
// - Table writes only touch holding buffers and take two cycles.
// - A row needs 64 low and 64 high writes and its own program cycle; the code starts a row program whatever the load counts.
// - Write-start begins the operation, stalls the core, then self-clears.
package psa_pkg;
  localparam int PSA_DW = 16;
  localparam int PSA_PW = 24;
  localparam int PSA_AW = 24;
  localparam int PSA_ROW_WORDS = 64;
  localparam int PSA_PAGE_ROWS = 8;
  localparam int PSA_ROW_BITS = 6;
  localparam int PSA_PAGE_BITS = 3;
  localparam int PSA_CFG_BIT = 7;
  localparam int PSA_WIN_BIT = 15;
  localparam int PSA_VIS_EN_BIT = 2;
  localparam logic [7:0] PSA_KEY1 = 8'h55;
  localparam logic [7:0] PSA_KEY2 = 8'hAA;
  localparam int PSA_WR_BIT = 15;
  localparam int PSA_WREN_BIT = 14;
  localparam int PSA_WRERR_BIT = 13;
  localparam int PSA_ERASE_BIT = 6;
  localparam logic [3:0] PSA_OP_WORD = 4'h3;
  localparam logic [3:0] PSA_OP_PAGE = 4'h2;
  localparam logic [3:0] PSA_OP_ROW = 4'h1;
  localparam logic [15:0] PSA_CTRL_MASK = 16'h704F;
  localparam logic [15:0] PSA_RESET_16 = 16'h0000;
  localparam logic [7:0] PSA_RESET_8 = 8'h00;
  localparam int PSA_TBLWR_CYCLES = 2;
  localparam int PSA_PROG_NS = 4000000;
  localparam int PSA_CLK_NS = 10;
  localparam int PSA_PROG_CYCLES = PSA_PROG_NS / PSA_CLK_NS;
  // Register offsets on the plain port (index = word address)
  localparam logic [3:0] PSA_REG_TBLPAGE = 4'h0;
  localparam logic [3:0] PSA_REG_VISPAGE = 4'h1;
  localparam logic [3:0] PSA_REG_CORE = 4'h2;
  localparam logic [3:0] PSA_REG_FCTRL = 4'h3;
  localparam logic [3:0] PSA_REG_KEY = 4'h4;
  localparam logic [3:0] PSA_REG_ROWCNT = 4'h5;
  typedef enum logic [3:0] {
    PSA_IDLE = 4'b0001,
    PSA_TWAIT = 4'b0010,
    PSA_EXTRA = 4'b0100,
    PSA_FLASH = 4'b1000
  } psa_state_t;
endpackage

// file: design/psa_flash_if.sv
/*
  Interface between the access unit and its flash sequencer.
  Assumes both ends share clk_i.
*/
`timescale 1ns/1ps
interface psa_flash_if;
  logic start;
  logic [3:0] op;
  logic erase;
  logic [23:0] addr;
  logic busy;
  logic done;
  modport ctrl (output start, op, erase, addr, input busy, done);
  modport seq (input start, op, erase, addr, output busy, done);
endinterface

// file: design/psa_flash_seq.sv
/*
  Self-timed flash operation sequencer: counts the programming time.
  Assumes start is a one-cycle pulse from the access unit.
*/
`timescale 1ns/1ps
module psa_flash_seq import psa_pkg::*; #(
  parameter int PROG_CYCLES = PSA_PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  psa_flash_if.seq fl
);
  logic [31:0] cnt;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 32'h00000000;
      fl.busy <= 1'b0;
      fl.done <= 1'b0;
    end else begin
      fl.done <= 1'b0;
      if (fl.start && !fl.busy) begin
        fl.busy <= 1'b1;
        cnt <= 32'(PROG_CYCLES - 1);
      end else if (fl.busy) begin
        if (cnt == 32'h00000000) begin
          fl.busy <= 1'b0;
          fl.done <= 1'b1;
        end else begin
          cnt <= cnt - 32'h00000001;
        end
      end
    end
  end
endmodule

// file: design/psa_top.sv
/*
  Program space access unit: table reads and writes, the visibility window,
  holding buffers and the flash control and unlock sequence.
  Assumes the core presents one access per request pulse and waits on stall_o;
  flash array read data arrives combinationally from the same clock domain.
*/
`timescale 1ns/1ps
module psa_top import psa_pkg::*; #(
  parameter int PROG_CYCLES = PSA_PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Table operations
  input wire logic tbl_req_i,
  input wire logic tbl_write_i,
  input wire logic tbl_high_i,
  input wire logic tbl_byte_i,
  input wire logic [15:0] effective_address_i,
  input wire logic [15:0] tbl_wdata_i,
  // Data-space reads that may fall in the window
  input wire logic data_rd_i,
  input wire logic [15:0] data_addr_i,
  input wire logic data_is_move_i,
  input wire logic repeat_active_i,
  input wire logic repeat_edge_i,
  // Flash array read port
  output logic [23:0] flash_addr_o,
  output logic flash_rd_o,
  input wire logic [23:0] flash_rdata_i,
  // Results
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic win_hit_o,
  output logic stall_o,
  output logic [23:0] prog_addr_o,
  output logic prog_start_o
);
  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0] table_page_register;
  logic [7:0] visibility_page_register;
  logic [15:0] core_control_register;
  logic [15:0] flash_control_register;
  logic key_armed;
  logic key_ok;
  logic [PSA_ROW_BITS-1:0] fill_idx;
  logic [PSA_ROW_BITS:0] low_cnt;
  logic [PSA_ROW_BITS:0] high_cnt;
  logic [23:0] row_base;
  logic [PSA_PW-1:0] hold_buf [PSA_ROW_WORDS];
  psa_state_t state;
  logic [1:0] extra_cnt;
  logic [1:0] next_extra;
  psa_flash_if fl ();

  psa_flash_seq #(.PROG_CYCLES(PROG_CYCLES)) u_seq (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .fl(fl)
  );

  // ==========================================================
  // Address formation
  // ==========================================================
  logic [23:0] tbl_addr;
  logic [23:0] win_addr;
  logic win_sel;
  logic tbl_cfg;
  logic byte_sel;
  logic [PSA_ROW_BITS-1:0] word_idx;
  assign tbl_addr = {table_page_register, effective_address_i};
  assign tbl_cfg = table_page_register[PSA_CFG_BIT];
  // Bit 15 of the data address is dropped; page bit 0 lands on program bit 15
  assign win_addr = {1'b0, visibility_page_register, data_addr_i[14:0]};
  assign win_sel = data_addr_i[PSA_WIN_BIT] && core_control_register[PSA_VIS_EN_BIT]
                   && (state != PSA_TWAIT);
  assign byte_sel = effective_address_i[0];
  // Address bit 0 selects a byte; words step by two
  assign word_idx = effective_address_i[PSA_ROW_BITS:1];

  // Read-data shaping for table reads
  function automatic logic [15:0] tbl_shape(input logic [23:0] w, input logic hi,
                                             input logic bm, input logic bs);
    logic [15:0] r;
    r = 16'h0000;
    if (!hi) begin
      if (bm) r = {8'h00, bs ? w[15:8] : w[7:0]};
      else r = w[15:0];
    end else begin
      if (bm) r = bs ? 16'h0000 : {8'h00, w[23:16]};
      else r = {8'h00, w[23:16]};
    end
    return r;
  endfunction

  // ==========================================================
  // Core access sequencing
  // ==========================================================
  logic tbl_rd_go;
  logic tbl_wr_go;
  logic win_go;
  assign tbl_rd_go = tbl_req_i && !tbl_write_i && (state == PSA_IDLE);
  assign tbl_wr_go = tbl_req_i && tbl_write_i && (state == PSA_IDLE);
  assign win_go = data_rd_i && win_sel && !tbl_req_i && (state == PSA_IDLE);

  // Extra cycle cost of a window read
  always_comb begin
    next_extra = 2'd0;
    if (repeat_active_i) begin
      next_extra = repeat_edge_i ? 2'd2 : 2'd0;
    end else begin
      next_extra = data_is_move_i ? 2'd1 : 2'd2;
    end
  end

  logic [23:0] rd_word_q;
  logic rd_high_q;
  logic rd_byte_q;
  logic rd_bs_q;
  logic rd_is_win_q;
  logic rd_pend;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= PSA_IDLE;
      extra_cnt <= 2'd0;
    end else begin
      unique case (state)
        PSA_IDLE: begin
          if (tbl_wr_go) begin
            state <= PSA_TWAIT;
            // The request cycle counts as the first of the two write cycles
            extra_cnt <= 2'(PSA_TBLWR_CYCLES - 2);
          end else if (tbl_rd_go) begin
            state <= PSA_TWAIT;
            extra_cnt <= 2'd0;
          end else if (win_go && next_extra != 2'd0) begin
            state <= PSA_EXTRA;
            extra_cnt <= next_extra - 2'd1;
          end else if (fl.start) begin
            state <= PSA_FLASH;
          end
        end
        PSA_TWAIT, PSA_EXTRA: begin
          if (extra_cnt == 2'd0) state <= PSA_IDLE;
          else extra_cnt <= extra_cnt - 2'd1;
        end
        PSA_FLASH: begin
          if (fl.done) state <= PSA_IDLE;
        end
      endcase
    end
  end

  // Flash array read request and results
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flash_addr_o <= 24'h000000;
      flash_rd_o <= 1'b0;
      rd_pend <= 1'b0;
      rd_high_q <= 1'b0;
      rd_byte_q <= 1'b0;
      rd_bs_q <= 1'b0;
      rd_is_win_q <= 1'b0;
    end else begin
      flash_rd_o <= tbl_rd_go || win_go;
      rd_pend <= tbl_rd_go || win_go;
      if (tbl_rd_go) begin
        flash_addr_o <= tbl_addr;
        rd_high_q <= tbl_high_i;
        rd_byte_q <= tbl_byte_i;
        rd_bs_q <= byte_sel;
        rd_is_win_q <= 1'b0;
      end else if (win_go) begin
        flash_addr_o <= win_addr;
        rd_is_win_q <= 1'b1;
      end
    end
  end
  assign rd_word_q = flash_rdata_i;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
      rvalid_o <= 1'b0;
      win_hit_o <= 1'b0;
    end else begin
      rvalid_o <= rd_pend;
      win_hit_o <= rd_pend && rd_is_win_q;
      if (rd_pend) begin
        if (rd_is_win_q) rdata_o <= rd_word_q[15:0];
        else rdata_o <= tbl_shape(rd_word_q, rd_high_q, rd_byte_q, rd_bs_q);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) stall_o <= 1'b0;
    else stall_o <= (tbl_wr_go || (win_go && next_extra != 2'd0) || fl.start
                     || (state == PSA_TWAIT && extra_cnt != 2'd0)
                     || (state == PSA_EXTRA && extra_cnt != 2'd0)
                     || (state == PSA_FLASH && !fl.done));
  end

  // ==========================================================
  // Holding buffers
  // ==========================================================
  // Writes land only in the buffer; the array changes on a program cycle
  always_ff @(posedge clk_i) begin
    if (tbl_wr_go && !tbl_cfg) begin
      if (tbl_high_i) begin
        if (!tbl_byte_i || !byte_sel) hold_buf[word_idx][23:16] <= tbl_wdata_i[7:0];
      end else if (tbl_byte_i) begin
        if (byte_sel) hold_buf[word_idx][15:8] <= tbl_wdata_i[7:0];
        else hold_buf[word_idx][7:0] <= tbl_wdata_i[7:0];
      end else begin
        hold_buf[word_idx][15:0] <= tbl_wdata_i;
      end
    end
  end

  // Counts loads for the row; relies on in-order loads from one aligned group
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_cnt <= '0;
      high_cnt <= '0;
      fill_idx <= '0;
      row_base <= 24'h000000;
    end else if (fl.done) begin
      low_cnt <= '0;
      high_cnt <= '0;
    end else if (tbl_wr_go) begin
      // Row and page bases align to zero by masking low address bits
      row_base <= {tbl_addr[23:PSA_ROW_BITS+1], {(PSA_ROW_BITS+1){1'b0}}};
      fill_idx <= word_idx;
      if (tbl_high_i) high_cnt <= high_cnt + 1'b1;
      else low_cnt <= low_cnt + 1'b1;
    end
  end

  // ==========================================================
  // Flash control and unlock
  // ==========================================================
  logic ctrl_wr;
  logic wr_set_try;
  logic [3:0] op_sel;
  logic op_valid;
  assign ctrl_wr = reg_wr_i && reg_addr_i == PSA_REG_FCTRL;
  assign wr_set_try = ctrl_wr && reg_wdata_i[PSA_WR_BIT] && !flash_control_register[PSA_WR_BIT];
  assign op_sel = flash_control_register[3:0];
  assign op_valid = flash_control_register[PSA_ERASE_BIT] ? (op_sel == PSA_OP_PAGE)
                    : (op_sel == PSA_OP_ROW || op_sel == PSA_OP_WORD);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      key_armed <= 1'b0;
      key_ok <= 1'b0;
    end else if (reg_wr_i) begin
      // Any other write between the keys breaks the sequence
      key_armed <= reg_addr_i == PSA_REG_KEY && reg_wdata_i[7:0] == PSA_KEY1;
      if (reg_addr_i == PSA_REG_KEY) key_ok <= key_armed && reg_wdata_i[7:0] == PSA_KEY2;
      else if (ctrl_wr) key_ok <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flash_control_register <= PSA_RESET_16;
      fl.start <= 1'b0;
      fl.op <= 4'h0;
      fl.erase <= 1'b0;
      fl.addr <= 24'h000000;
    end else begin
      fl.start <= 1'b0;
      if (fl.done) flash_control_register[PSA_WR_BIT] <= 1'b0;
      if (ctrl_wr) begin
        flash_control_register[PSA_WREN_BIT] <= reg_wdata_i[PSA_WREN_BIT];
        flash_control_register[PSA_ERASE_BIT] <= reg_wdata_i[PSA_ERASE_BIT];
        flash_control_register[3:0] <= reg_wdata_i[3:0];
        if (!reg_wdata_i[PSA_WRERR_BIT]) flash_control_register[PSA_WRERR_BIT] <= 1'b0;
        if (wr_set_try) begin
          if (key_ok && flash_control_register[PSA_WREN_BIT] && op_valid) begin
            flash_control_register[PSA_WR_BIT] <= 1'b1;
            fl.start <= 1'b1;
            fl.op <= op_sel;
            fl.erase <= flash_control_register[PSA_ERASE_BIT];
            fl.addr <= row_base;
          end else begin
            flash_control_register[PSA_WRERR_BIT] <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prog_start_o <= 1'b0;
      prog_addr_o <= 24'h000000;
    end else begin
      prog_start_o <= fl.start;
      if (fl.start) prog_addr_o <= fl.erase
        ? {fl.addr[23:PSA_ROW_BITS+PSA_PAGE_BITS+1], {(PSA_ROW_BITS+PSA_PAGE_BITS+1){1'b0}}}
        : fl.addr;
    end
  end

  // ==========================================================
  // Other software registers
  // ==========================================================
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      table_page_register <= PSA_RESET_8;
      visibility_page_register <= PSA_RESET_8;
      core_control_register <= PSA_RESET_16;
    end else if (reg_wr_i) begin
      if (reg_addr_i == PSA_REG_TBLPAGE) table_page_register <= reg_wdata_i[7:0];
      if (reg_addr_i == PSA_REG_VISPAGE) visibility_page_register <= reg_wdata_i[7:0];
      if (reg_addr_i == PSA_REG_CORE) core_control_register <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) reg_rdata_o <= 16'h0000;
    else if (reg_rd_i) begin
      unique case (reg_addr_i)
        PSA_REG_TBLPAGE: reg_rdata_o <= {8'h00, table_page_register};
        PSA_REG_VISPAGE: reg_rdata_o <= {8'h00, visibility_page_register};
        PSA_REG_CORE: reg_rdata_o <= core_control_register;
        PSA_REG_FCTRL: reg_rdata_o <= flash_control_register & PSA_CTRL_MASK;
        PSA_REG_ROWCNT: reg_rdata_o <= {1'b0, high_cnt, 1'b0, low_cnt};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end
endmodule

// file: testbench/psa_flash_model.sv
/*
  Behavioural flash array read port for the access unit.
  Assumes the unit samples read data at the edge that ends its read strobe.
*/
`timescale 1ns/1ps
module psa_flash_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic flash_rd_i,
  input wire logic [23:0] flash_addr_i,
  output logic [23:0] flash_rdata_o
);
  logic [23:0] last;
  // ==========================================
  // Read port
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last <= 24'h000000;
    end else if (flash_rd_i) begin
      last <= flash_rdata_o;
    end
  end
  // Data stand while the strobe is high; otherwise the inverse of the last word, so stale use is seen
  assign flash_rdata_o = flash_rd_i ? {flash_addr_i[7:0] ^ 8'hA5, flash_addr_i[15:0] ^ 16'h3C5A} : ~last;
endmodule

// file: testbench/psa_top_sva.sv
/*
  Port checker for psa_top.
  Assumes the core honours stall_o and the request spacing of the unit.
*/
`timescale 1ns/1ps
module psa_top_sva import psa_pkg::*; #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic tbl_req_i,
  input wire logic tbl_write_i,
  input wire logic tbl_high_i,
  input wire logic tbl_byte_i,
  input wire logic [15:0] effective_address_i,
  input wire logic data_rd_i,
  input wire logic [15:0] data_addr_i,
  input wire logic data_is_move_i,
  input wire logic repeat_active_i,
  input wire logic repeat_edge_i,
  input wire logic [23:0] flash_addr_o,
  input wire logic flash_rd_o,
  input wire logic [23:0] flash_rdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic win_hit_o,
  input wire logic stall_o,
  input wire logic prog_start_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================
  // Sequences
  sequence s_fetch;
    flash_rd_o;
  endsequence
  sequence s_win_fetch;
    flash_rd_o && $past(data_rd_i) && !$past(tbl_req_i);
  endsequence
  sequence s_hi_table;
    rvalid_o && !win_hit_o && $past(tbl_high_i, 2);
  endsequence
  // ==========================================
  // Assertions
  a_fetch_answer: assert property (s_fetch |=> rvalid_o) else $error("no answer after flash fetch");
  a_rvalid_pulse: assert property (rvalid_o |=> !rvalid_o) else $error("rvalid longer than one cycle");
  a_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("read data outside slot");
  a_tbl_addr: assert property (s_fetch and $past(tbl_req_i) |-> flash_addr_o[15:0] == $past(effective_address_i))
    else $error("table address wrong");
  a_win_addr: assert property (s_win_fetch |-> !flash_addr_o[23] && flash_addr_o[14:0] == $past(data_addr_i[14:0]))
    else $error("window address wrong");
  a_win_data: assert property (win_hit_o |-> rvalid_o && rdata_o == $past(flash_rdata_i[15:0]))
    else $error("window data wrong");
  a_high_word: assert property (s_hi_table and !$past(tbl_byte_i, 2) |-> rdata_o == {8'h00, $past(flash_rdata_i[23:16])})
    else $error("high word read wrong");
  a_phantom_zero: assert property (s_hi_table and $past(tbl_byte_i & effective_address_i[0], 2) |-> rdata_o == 16'h0000)
    else $error("phantom byte not zero");
  a_move_extra: assert property (s_win_fetch and $past(data_is_move_i & !repeat_active_i) |-> stall_o ##1 !stall_o)
    else $error("move extra cycle wrong");
  a_repeat_free: assert property (s_win_fetch and $past(repeat_active_i & !repeat_edge_i) |-> !stall_o)
    else $error("repeat iteration stalled");
  a_tblwr_stall: assert property (tbl_req_i && tbl_write_i && !stall_o |=> stall_o ##1 !stall_o)
    else $error("table write length wrong");
  a_prog_stall: assert property (prog_start_o |=> stall_o [*8])
    else $error("core not stalled during operation");
endmodule

// file: testbench/psa_top_test.sv
/*
  Self-checking bench for psa_top with a behavioural flash array.
  Assumes a 100 MHz clock and a shortened programming time.
*/
`timescale 1ns/1ps
module psa_top_test import psa_pkg::*;;
  localparam int PROG_CYCLES = 20;
  logic clk_i, rstn_i, reg_wr_i, reg_rd_i, tbl_req_i, tbl_write_i, tbl_high_i, tbl_byte_i;
  logic data_rd_i, data_is_move_i, repeat_active_i, repeat_edge_i, flash_rd_o, rvalid_o, win_hit_o, stall_o, prog_start_o;
  logic [3:0] reg_addr_i;
  logic [15:0] reg_wdata_i, effective_address_i, tbl_wdata_i, data_addr_i, reg_rdata_o, rdata_o, d;
  logic [23:0] flash_addr_o, flash_rdata_i, prog_addr_o, w;
  int n_fail, comparisons;
  psa_top #(.PROG_CYCLES(PROG_CYCLES)) i_psa_top (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .tbl_req_i(tbl_req_i), .tbl_write_i(tbl_write_i), .tbl_high_i(tbl_high_i), .tbl_byte_i(tbl_byte_i),
    .effective_address_i(effective_address_i), .tbl_wdata_i(tbl_wdata_i), .data_rd_i(data_rd_i),
    .data_addr_i(data_addr_i), .data_is_move_i(data_is_move_i), .repeat_active_i(repeat_active_i),
    .repeat_edge_i(repeat_edge_i), .flash_addr_o(flash_addr_o), .flash_rd_o(flash_rd_o),
    .flash_rdata_i(flash_rdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .win_hit_o(win_hit_o),
    .stall_o(stall_o), .prog_addr_o(prog_addr_o), .prog_start_o(prog_start_o));
  psa_flash_model i_psa_flash_model (.clk_i(clk_i), .rstn_i(rstn_i), .flash_rd_i(flash_rd_o),
    .flash_addr_i(flash_addr_o), .flash_rdata_o(flash_rdata_i));
  // ==========================================
  // Shared tasks
  task check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out();
    $display("Checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task reg_rd(input logic [3:0] a);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task tbl_op(input logic wr, input logic hi, input logic by, input logic [15:0] ea);
    @(posedge clk_i);
    tbl_req_i <= 1'b1;
    {tbl_write_i, tbl_high_i, tbl_byte_i} <= {wr, hi, by};
    effective_address_i <= ea;
    tbl_wdata_i <= ea ^ 16'h00FF;
    @(posedge clk_i);
    tbl_req_i <= 1'b0;
    #1;
  endtask
  // ==========================================
  // Scenarios
  task t_regs();
    for (int r = 0; r < 6; r++) begin
      reg_rd(4'(r));
      check(24'(d), 24'h0);
    end
    reg_wr(4'h6, 16'hFFFF);
    reg_rd(4'h6);
    check(24'(d), 24'h0);
    reg_wr(PSA_REG_KEY, 16'h0055);
    reg_rd(PSA_REG_KEY);
    check(24'(d), 24'h0);
  endtask
  task t_tbl_reads();
    logic [7:0] pg;
    logic [15:0] ea, exp;
    for (int p = 0; p < 2; p++) begin
      pg = p ? 8'h92 : 8'h12;
      reg_wr(PSA_REG_TBLPAGE, {8'h00, pg});
      for (int k = 0; k < 8; k++) begin
        ea = 16'h5A40 | 16'(k[0] & k[1]);
        w = {ea[7:0] ^ 8'hA5, ea ^ 16'h3C5A};
        if (!k[2]) exp = !k[1] ? w[15:0] : (ea[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]});
        else exp = (k[1] && ea[0]) ? 16'h0000 : {8'h00, w[23:16]};
        tbl_op(1'b0, k[2], k[1], ea);
        check(flash_addr_o, {pg, ea});
        @(posedge clk_i);
        #1 check(24'(rdata_o), 24'(exp));
        check(24'(rvalid_o), 24'h1);
      end
    end
  endtask
  task win_rd(input logic [15:0] a, input logic mv, input logic rp, input logic ed, input logic hit, input int extra);
    int n;
    logic h;
    @(posedge clk_i);
    data_rd_i <= 1'b1;
    data_addr_i <= a;
    {data_is_move_i, repeat_active_i, repeat_edge_i} <= {mv, rp, ed};
    @(posedge clk_i);
    data_rd_i <= 1'b0;
    #1 n = 0;
    h = 1'b0;
    w = {1'b0, 8'h35, a[14:0]};
    if (hit) check(flash_addr_o, w);
    for (int i = 0; i < 4; i++) begin
      if (stall_o === 1'b1) n++;
      if (win_hit_o === 1'b1) h = 1'b1;
      if (win_hit_o === 1'b1) d = rdata_o;
      @(posedge clk_i);
      #1;
    end
    check(24'(h), 24'(hit));
    if (hit) check(24'(d), 24'(w[15:0] ^ 16'h3C5A));
    check(24'(n), 24'(extra));
  endtask
  task t_window();
    reg_wr(PSA_REG_VISPAGE, 16'h0035);
    reg_wr(PSA_REG_CORE, 16'h0004);
    win_rd(16'hC123, 1'b1, 1'b0, 1'b0, 1'b1, 1);
    win_rd(16'h8002, 1'b0, 1'b0, 1'b0, 1'b1, 2);
    win_rd(16'hFFFE, 1'b0, 1'b1, 1'b1, 1'b1, 2);
    win_rd(16'hC124, 1'b1, 1'b1, 1'b0, 1'b1, 0);
    win_rd(16'h7FFE, 1'b0, 1'b0, 1'b0, 1'b0, 0);
    // Table read and window read offered together: the table wins
    @(posedge clk_i);
    {data_rd_i, tbl_req_i, tbl_write_i, tbl_high_i, tbl_byte_i} <= 5'h18;
    data_addr_i <= 16'hC000;
    effective_address_i <= 16'h0010;
    @(posedge clk_i);
    {data_rd_i, tbl_req_i} <= 2'h0;
    #1 check(flash_addr_o, 24'h920010);
    @(posedge clk_i);
    #1 check(24'(win_hit_o), 24'h0);
    check(24'(rvalid_o), 24'h1);
    reg_wr(PSA_REG_CORE, 16'h0000);
    win_rd(16'hC123, 1'b0, 1'b0, 1'b0, 1'b0, 0);
  endtask
  task start_op(input logic [15:0] ctl, input logic [23:0] exp);
    int k;
    reg_wr(PSA_REG_FCTRL, ctl);
    reg_wr(PSA_REG_KEY, {8'h00, PSA_KEY1});
    reg_wr(PSA_REG_KEY, {8'h00, PSA_KEY2});
    reg_wr(PSA_REG_FCTRL, ctl | 16'h8000);
    for (k = 0; k < 10 && prog_start_o !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    check(24'(prog_start_o), 24'h1);
    if (exp != 24'h0) check(prog_addr_o, exp);
    for (k = 0; k < PROG_CYCLES + 20 && stall_o !== 1'b0; k++) #10;
    reg_rd(PSA_REG_FCTRL);
    check(24'(d[15]), 24'h0);
  endtask
  task t_flash();
    reg_wr(PSA_REG_TBLPAGE, 16'h0001);
    // Buffer loaded in order from one aligned group
    for (int i = 0; i < 3; i++) begin
      tbl_op(1'b1, 1'b0, 1'b0, 16'(2 * i));
      tbl_op(1'b1, 1'b1, 1'b0, 16'(2 * i));
    end
    reg_rd(PSA_REG_ROWCNT);
    check(24'(d), 24'h000303);
    start_op(16'h4001, 24'h010000);
    tbl_op(1'b1, 1'b0, 1'b0, 16'h0A46);
    start_op(16'h4042, 24'h010800);
    reg_wr(PSA_REG_FCTRL, 16'hC001);
    reg_rd(PSA_REG_FCTRL);
    check(24'(d[15:13]), 24'h3);
  endtask
  // ==========================================
  // Clock, reset, sequence and watchdog
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {rstn_i, reg_wr_i, reg_rd_i, tbl_req_i, tbl_write_i, tbl_high_i, tbl_byte_i} = '0;
    {data_rd_i, data_is_move_i, repeat_active_i, repeat_edge_i} = '0;
    reg_addr_i = 4'h0;
    {reg_wdata_i, effective_address_i, tbl_wdata_i, data_addr_i} = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_tbl_reads();
    t_window();
    t_flash();
    close_out();
  end
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
endmodule
bind psa_top psa_top_sva #(.PROG_CYCLES(PROG_CYCLES)) i_psa_top_sva (.clk_i(clk_i), .rstn_i(rstn_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tbl_req_i(tbl_req_i), .tbl_write_i(tbl_write_i),
  .tbl_high_i(tbl_high_i), .tbl_byte_i(tbl_byte_i), .effective_address_i(effective_address_i),
  .data_rd_i(data_rd_i), .data_addr_i(data_addr_i), .data_is_move_i(data_is_move_i),
  .repeat_active_i(repeat_active_i), .repeat_edge_i(repeat_edge_i), .flash_addr_o(flash_addr_o),
  .flash_rd_o(flash_rd_o), .flash_rdata_i(flash_rdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .win_hit_o(win_hit_o), .stall_o(stall_o), .prog_start_o(prog_start_o));
